// ### psb_pkg.sv
// Shared constants and types for the PIPE simulation bus packer
package psb_pkg;

	// Lane count and vector widths
	localparam int LANES     = 2;
	localparam int LANE_W    = 39;
	localparam int RX_W      = 84;
	localparam int TX_W      = 70;
	localparam int CMN_IN_W  = 26;
	localparam int CMN_OUT_W = 17;

	// Per-lane field positions; bits 38:0 shared by both directions, 39 and up transmit only
	localparam int SYM_LO    = 0;
	localparam int SYM_HI    = 31;
	localparam int CHK_LO    = 32;
	localparam int CHK_HI    = 33;
	localparam int IDLE_BIT  = 34;
	localparam int QUAL_BIT  = 35;
	localparam int BLK_BIT   = 36;
	localparam int HDR_LO    = 37;
	localparam int HDR_HI    = 38;
	localparam int POL_BIT   = 39;
	localparam int PWR_LO    = 40;
	localparam int PWR_HI    = 41;
	localparam int TX_SPARE_LO = 42;

	// Common output vector positions
	localparam int CLK_BIT    = 0;
	localparam int RATE_LO    = 1;
	localparam int RATE_HI    = 2;
	localparam int RXDET_BIT  = 3;
	localparam int MARGIN_LO  = 4;
	localparam int MARGIN_HI  = 6;
	localparam int SWING_BIT  = 7;
	localparam int TXRST_BIT  = 8;
	localparam int DEEMPH_BIT = 9;
	localparam int CMN_SPARE_LO = 10;

	// Interface clock figures and the divider counts derived from them
	localparam int LINK_CLK_MHZ  = 500;
	localparam int PCLK_GEN1_MHZ = 125;
	localparam int PCLK_FAST_MHZ = 250;
	localparam logic [1:0] GEN1_HALF = 2'(LINK_CLK_MHZ / (2 * PCLK_GEN1_MHZ));
	localparam logic [1:0] FAST_HALF = 2'(LINK_CLK_MHZ / (2 * PCLK_FAST_MHZ));

	localparam int FIFO_DEPTH = 32;

	typedef enum logic [1:0]
	{
		PSB_GEN1 = 2'h0,
		PSB_GEN2 = 2'h1,
		PSB_GEN3 = 2'h2
	} psb_rate_t;

	typedef enum logic [1:0]
	{
		PSB_OFF    = 2'h0,
		PSB_IDLE   = 2'h1,
		PSB_ACTIVE = 2'h3
	} psb_link_state_t;

	typedef struct packed
	{
		logic [1:0]             rate;
		logic                   rxdet;
		logic [2:0]             margin;
		logic                   swing;
		logic                   txrst;
		logic                   deemph;
		logic [LANES-1:0]       inv;
		logic [LANES-1:0][1:0]  pwr;
	} psb_ctl_t;

endpackage

// ### psb_fifo.sv
// Dual-clock FIFO with gray pointers and a registered read word
`timescale 1ns/10ps
module psb_fifo #(
	parameter int W     = 78,
	parameter int DEPTH = 32
)(
	input  wire logic         wr_clk,
	input  wire logic         wr_rst,
	input  wire logic         wr_valid,
	output logic              wr_ready,
	input  wire logic [W-1:0] wr_data,
	input  wire logic         rd_clk,
	input  wire logic         rd_rst,
	output logic              rd_valid,
	input  wire logic         rd_ready,
	output logic [W-1:0]      rd_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [AW:0] bin;
		logic [AW:0] gray;
		logic [AW:0] rq1;
		logic [AW:0] rq2;
		logic        ready;
	} psb_fifo_wr_t;

	typedef struct packed
	{
		logic [AW:0]  bin;
		logic [AW:0]  gray;
		logic [AW:0]  wq1;
		logic [AW:0]  wq2;
		logic         valid;
		logic [W-1:0] data;
	} psb_fifo_rd_t;

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		to_gray = b ^ (b >> 1);
	endfunction

	psb_fifo_wr_t w_reg;
	psb_fifo_wr_t w_next;
	psb_fifo_rd_t r_reg;
	psb_fifo_rd_t r_next;
	logic [W-1:0] mem [DEPTH];
	logic         push;

	always_comb
	begin
		w_next = w_reg;
		push = wr_valid && w_reg.ready;
		w_next.rq1 = r_reg.gray;
		w_next.rq2 = w_reg.rq1;
		if (push)
		begin
			w_next.bin = w_reg.bin + 1'b1;
		end
		w_next.gray = to_gray(w_next.bin);
		// Full is judged against a stale read pointer, so it can only err towards full; low through reset
		w_next.ready = w_next.gray != {~w_reg.rq2[AW:AW-1], w_reg.rq2[AW-2:0]};
	end

	always_ff @(posedge wr_clk or posedge wr_rst)
	begin
		if (wr_rst)
			w_reg <= '0;
		else
			w_reg <= w_next;
	end

	always_ff @(posedge wr_clk)
	begin
		if (push)
			mem[w_reg.bin[AW-1:0]] <= wr_data;
	end

	always_comb
	begin
		r_next = r_reg;
		r_next.wq1 = w_reg.gray;
		r_next.wq2 = r_reg.wq1;
		if (r_reg.gray != r_reg.wq2 && (!r_reg.valid || rd_ready))
		begin
			r_next.data = mem[r_reg.bin[AW-1:0]];
			r_next.valid = 1'b1;
			r_next.bin = r_reg.bin + 1'b1;
		end
		else if (rd_ready)
		begin
			r_next.valid = 1'b0;
		end
		r_next.gray = to_gray(r_next.bin);
	end

	always_ff @(posedge rd_clk or posedge rd_rst)
	begin
		if (rd_rst)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign wr_ready = w_reg.ready;
	assign rd_valid = r_reg.valid;
	assign rd_data  = r_reg.data;

	full_blocks_a: assert property (@(posedge wr_clk) disable iff (wr_rst)
		wr_valid && !wr_ready |=> $stable(w_reg.bin))
		else $error("Write pointer moved while full");

	word_holds_a: assert property (@(posedge rd_clk) disable iff (rd_rst)
		rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
		else $error("Read word changed before it was taken");

endmodule

// ### psb_top.sv
// PIPE lane and common signal packer at the core boundary, link side on its own clock
//
// Summary of operation
// - PIPE connects straight to partner, no transceivers
// - Enabled option brings PIPE signals to boundary
// - Interface clock out: 125 or 250 MHz
// - Rate code: 00 gen1, 01 gen2, 10 gen3
// - Common vector layout; all common inputs ignored
// - Lane bits 31:0 symbols, 33:32 control flags
// - Lane bit 34 idle, bit 35 qualifier
// - Lane bit 36 block start, 38:37 header
// - Transmit 39 invert, 41:40 power; rest unused
`timescale 1ns/10ps
module psb_top (
	input  wire logic                                   clk,
	input  wire logic                                   reset,
	input  wire logic                                   link_clk,
	input  wire logic                                   ext_pipe_enable,
	input  wire logic [1:0]                             line_rate_sel,
	input  wire logic                                   receiver_detect_req,
	input  wire logic [2:0]                             tx_voltage_margin,
	input  wire logic                                   tx_swing_sel,
	input  wire logic                                   tx_phy_reset,
	input  wire logic                                   tx_deemphasis_sel,
	input  wire logic [psb_pkg::LANES-1:0]              rx_invert_req,
	input  wire logic [psb_pkg::LANES-1:0][1:0]         lane_power_state,
	input  wire logic                                   tx_valid,
	output logic                                        tx_ready,
	input  wire logic [psb_pkg::LANES-1:0][31:0]        lane_tx_symbols,
	input  wire logic [psb_pkg::LANES-1:0][1:0]         tx_control_char_flag,
	input  wire logic [psb_pkg::LANES-1:0]              tx_idle_state,
	input  wire logic [psb_pkg::LANES-1:0]              tx_word_qualifier,
	input  wire logic [psb_pkg::LANES-1:0]              tx_block_begin,
	input  wire logic [psb_pkg::LANES-1:0][1:0]         tx_block_header,
	output logic                                        rx_valid,
	input  wire logic                                   rx_ready,
	output logic [psb_pkg::LANES-1:0][31:0]             lane_rx_symbols,
	output logic [psb_pkg::LANES-1:0][1:0]              rx_control_char_flag,
	output logic [psb_pkg::LANES-1:0]                   rx_idle_state,
	output logic [psb_pkg::LANES-1:0]                   rx_word_qualifier,
	output logic [psb_pkg::LANES-1:0]                   rx_block_begin,
	output logic [psb_pkg::LANES-1:0][1:0]              rx_block_header,
	output logic                                        rx_overflow,
	input  wire logic                                   rx_overflow_clr,
	input  wire logic [psb_pkg::CMN_IN_W-1:0]           common_cmd_in,
	output logic [psb_pkg::CMN_OUT_W-1:0]               common_cmd_out,
	input  wire logic [psb_pkg::LANES-1:0][psb_pkg::RX_W-1:0] lane_rx_bus,
	output logic [psb_pkg::LANES-1:0][psb_pkg::TX_W-1:0]      lane_tx_bus
);
	localparam int LW = psb_pkg::LANES * psb_pkg::LANE_W;

	typedef struct packed
	{
		logic              en;
		psb_pkg::psb_ctl_t ctl;
		logic              drop_s1;
		logic              drop_s2;
		logic              drop_s3;
		logic              overflow;
	} psb_core_t;

	typedef struct packed
	{
		logic                                             en_s1;
		logic                                             en_s2;
		psb_pkg::psb_ctl_t                                ctl_s1;
		psb_pkg::psb_ctl_t                                ctl_s2;
		psb_pkg::psb_link_state_t                         state;
		logic [1:0]                                       div_cnt;
		logic                                             pclk;
		logic [psb_pkg::CMN_OUT_W-1:0]                    cmn_out;
		logic [psb_pkg::LANES-1:0][psb_pkg::TX_W-1:0]     tx_bus;
		logic [psb_pkg::LANES-1:0][psb_pkg::LANE_W-1:0]   rx_word;
		logic                                             rx_push;
		logic                                             drop_tgl;
	} psb_link_t;

	// Illegal code 2'h3 falls back to the slowest rate
	function automatic psb_pkg::psb_rate_t rate_code(input logic [1:0] sel);
		case (sel)
			2'h1:    rate_code = psb_pkg::PSB_GEN2;
			2'h2:    rate_code = psb_pkg::PSB_GEN3;
			default: rate_code = psb_pkg::PSB_GEN1;
		endcase
	endfunction

	function automatic logic [psb_pkg::LANE_W-1:0] idle_word();
		idle_word = '0;
		idle_word[psb_pkg::IDLE_BIT] = 1'b1;
	endfunction

	psb_core_t ck_reg;
	psb_core_t ck_next;
	psb_link_t lk_reg;
	psb_link_t lk_next;
	logic      link_rst_s1;
	logic      link_rst;
	logic      link_load;

	logic [psb_pkg::LANES-1:0][psb_pkg::LANE_W-1:0] tx_wr_word;
	logic [psb_pkg::LANES-1:0][psb_pkg::LANE_W-1:0] tx_rd_word;
	logic [psb_pkg::LANES-1:0][psb_pkg::LANE_W-1:0] rx_rd_word;
	logic                                           tx_rd_valid;
	logic                                           rx_wr_ready;

	// Link-side reset: asserted at once, released on the link clock
	always_ff @(posedge link_clk or posedge reset)
	begin
		if (reset)
		begin
			link_rst_s1 <= 1'b1;
			link_rst <= 1'b1;
		end
		else
		begin
			link_rst_s1 <= 1'b0;
			link_rst <= link_rst_s1;
		end
	end

	// Core side: registered controls so the link samples glitch-free levels
	always_comb
	begin
		ck_next = ck_reg;
		ck_next.en = ext_pipe_enable;
		ck_next.ctl.rate = line_rate_sel;
		ck_next.ctl.rxdet = receiver_detect_req;
		ck_next.ctl.margin = tx_voltage_margin;
		ck_next.ctl.swing = tx_swing_sel;
		ck_next.ctl.txrst = tx_phy_reset;
		ck_next.ctl.deemph = tx_deemphasis_sel;
		ck_next.ctl.inv = rx_invert_req;
		ck_next.ctl.pwr = lane_power_state;
		ck_next.drop_s1 = lk_reg.drop_tgl;
		ck_next.drop_s2 = ck_reg.drop_s1;
		ck_next.drop_s3 = ck_reg.drop_s2;
		// A new drop beats a clear in the same cycle
		if (ck_reg.drop_s3 != ck_reg.drop_s2)
			ck_next.overflow = 1'b1;
		else if (rx_overflow_clr)
			ck_next.overflow = 1'b0;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ck_reg <= '0;
		else
			ck_reg <= ck_next;
	end

	// Link side
	always_comb
	begin
		psb_pkg::psb_rate_t rate;
		logic [1:0]         half;
		logic               tick;
		logic               on;
		rate = rate_code(lk_reg.ctl_s2.rate);
		half = (rate == psb_pkg::PSB_GEN1) ? psb_pkg::GEN1_HALF : psb_pkg::FAST_HALF;
		tick = lk_reg.div_cnt >= half - 2'h1;
		on = lk_reg.state != psb_pkg::PSB_OFF;
		link_load = on && tick && !lk_reg.pclk;
		lk_next = lk_reg;
		lk_next.en_s1 = ck_reg.en;
		lk_next.en_s2 = lk_reg.en_s1;
		lk_next.ctl_s1 = ck_reg.ctl;
		lk_next.ctl_s2 = lk_reg.ctl_s1;

		case (lk_reg.state)
			psb_pkg::PSB_OFF:
				if (lk_reg.en_s2)
					lk_next.state = psb_pkg::PSB_IDLE;
			psb_pkg::PSB_IDLE:
				if (!lk_reg.en_s2)
					lk_next.state = psb_pkg::PSB_OFF;
				else if (link_load && tx_rd_valid)
					lk_next.state = psb_pkg::PSB_ACTIVE;
			psb_pkg::PSB_ACTIVE:
				if (!lk_reg.en_s2)
					lk_next.state = psb_pkg::PSB_OFF;
				else if (link_load && !tx_rd_valid)
					lk_next.state = psb_pkg::PSB_IDLE;
			default:
				lk_next.state = psb_pkg::PSB_OFF;
		endcase

		if (!on)
		begin
			// Quiet boundary while the external interface is disabled
			lk_next.div_cnt = 2'h0;
			lk_next.pclk = 1'b0;
			lk_next.cmn_out = '0;
			lk_next.rx_push = 1'b0;
			for (int l = 0; l < psb_pkg::LANES; l++)
			begin
				lk_next.tx_bus[l] = '0;
				lk_next.tx_bus[l][psb_pkg::LANE_W-1:0] = idle_word();
			end
		end
		else
		begin
			// Interface clock divided down from the link clock
			if (tick)
			begin
				lk_next.div_cnt = 2'h0;
				lk_next.pclk = !lk_reg.pclk;
			end
			else
			begin
				lk_next.div_cnt = lk_reg.div_cnt + 2'h1;
			end
			// Common inputs are never read; spare outputs held low
			lk_next.cmn_out = '0;
			lk_next.cmn_out[psb_pkg::CLK_BIT] = lk_next.pclk;
			lk_next.cmn_out[psb_pkg::RATE_HI:psb_pkg::RATE_LO] = rate;
			lk_next.cmn_out[psb_pkg::RXDET_BIT] = lk_reg.ctl_s2.rxdet;
			lk_next.cmn_out[psb_pkg::MARGIN_HI:psb_pkg::MARGIN_LO] = lk_reg.ctl_s2.margin;
			lk_next.cmn_out[psb_pkg::SWING_BIT] = lk_reg.ctl_s2.swing;
			lk_next.cmn_out[psb_pkg::TXRST_BIT] = lk_reg.ctl_s2.txrst;
			lk_next.cmn_out[psb_pkg::DEEMPH_BIT] = lk_reg.ctl_s2.deemph;
			for (int l = 0; l < psb_pkg::LANES; l++)
			begin
				// One word per interface clock period, taken as the clock rises
				if (link_load)
					lk_next.tx_bus[l][psb_pkg::LANE_W-1:0] = tx_rd_valid ? tx_rd_word[l] : idle_word();
				lk_next.tx_bus[l][psb_pkg::POL_BIT] = lk_reg.ctl_s2.inv[l];
				lk_next.tx_bus[l][psb_pkg::PWR_HI:psb_pkg::PWR_LO] = lk_reg.ctl_s2.pwr[l];
				lk_next.tx_bus[l][psb_pkg::TX_W-1:psb_pkg::TX_SPARE_LO] = '0;
				// Receive bits above the lane word are never looked at
				lk_next.rx_word[l] = lane_rx_bus[l][psb_pkg::LANE_W-1:0];
			end
			lk_next.rx_push = 1'b0;
			for (int l = 0; l < psb_pkg::LANES; l++)
				lk_next.rx_push = lk_next.rx_push | lane_rx_bus[l][psb_pkg::QUAL_BIT];
		end
		// The link model cannot be stalled, so a full receive FIFO drops the word
		if (lk_reg.rx_push && !rx_wr_ready)
			lk_next.drop_tgl = !lk_reg.drop_tgl;
	end

	always_ff @(posedge link_clk or posedge link_rst)
	begin
		if (link_rst)
			lk_reg <= '0;
		else
			lk_reg <= lk_next;
	end

	always_comb
	begin
		for (int l = 0; l < psb_pkg::LANES; l++)
			tx_wr_word[l] = {tx_block_header[l], tx_block_begin[l], tx_word_qualifier[l], tx_idle_state[l],
				tx_control_char_flag[l], lane_tx_symbols[l]};
	end

	psb_fifo #(.W(LW), .DEPTH(psb_pkg::FIFO_DEPTH)) tx_fifo (
		.wr_clk   (clk),
		.wr_rst   (reset),
		.wr_valid (tx_valid),
		.wr_ready (tx_ready),
		.wr_data  (tx_wr_word),
		.rd_clk   (link_clk),
		.rd_rst   (link_rst),
		.rd_valid (tx_rd_valid),
		.rd_ready (link_load),
		.rd_data  (tx_rd_word)
	);

	psb_fifo #(.W(LW), .DEPTH(psb_pkg::FIFO_DEPTH)) rx_fifo (
		.wr_clk   (link_clk),
		.wr_rst   (link_rst),
		.wr_valid (lk_reg.rx_push),
		.wr_ready (rx_wr_ready),
		.wr_data  (lk_reg.rx_word),
		.rd_clk   (clk),
		.rd_rst   (reset),
		.rd_valid (rx_valid),
		.rd_ready (rx_ready),
		.rd_data  (rx_rd_word)
	);

	always_comb
	begin
		for (int l = 0; l < psb_pkg::LANES; l++)
		begin
			lane_rx_symbols[l] = rx_rd_word[l][psb_pkg::SYM_HI:psb_pkg::SYM_LO];
			rx_control_char_flag[l] = rx_rd_word[l][psb_pkg::CHK_HI:psb_pkg::CHK_LO];
			rx_idle_state[l] = rx_rd_word[l][psb_pkg::IDLE_BIT];
			rx_word_qualifier[l] = rx_rd_word[l][psb_pkg::QUAL_BIT];
			rx_block_begin[l] = rx_rd_word[l][psb_pkg::BLK_BIT];
			rx_block_header[l] = rx_rd_word[l][psb_pkg::HDR_HI:psb_pkg::HDR_LO];
		end
	end

	assign rx_overflow    = ck_reg.overflow;
	assign common_cmd_out = lk_reg.cmn_out;
	assign lane_tx_bus    = lk_reg.tx_bus;

	sequence fast_run;
		lk_reg.state != psb_pkg::PSB_OFF && lk_reg.ctl_s2.rate == 2'h1;
	endsequence

	sequence slow_run;
		lk_reg.state != psb_pkg::PSB_OFF && lk_reg.ctl_s2.rate == 2'h0;
	endsequence

	rate_legal_a: assert property (@(posedge link_clk) disable iff (link_rst)
		common_cmd_out[psb_pkg::RATE_HI:psb_pkg::RATE_LO] != 2'h3)
		else $error("Rate field carries an illegal code");

	fast_clock_a: assert property (@(posedge link_clk) disable iff (link_rst)
		fast_run [*3] |=> common_cmd_out[psb_pkg::CLK_BIT] != $past(common_cmd_out[psb_pkg::CLK_BIT]))
		else $error("Fast interface clock missed a toggle");

	slow_clock_a: assert property (@(posedge link_clk) disable iff (link_rst)
		slow_run [*4] ##0 $changed(common_cmd_out[psb_pkg::CLK_BIT]) |=> $stable(common_cmd_out[psb_pkg::CLK_BIT]))
		else $error("Slow interface clock toggled too soon");

	common_spare_a: assert property (@(posedge link_clk) disable iff (link_rst)
		common_cmd_out[psb_pkg::CMN_OUT_W-1:psb_pkg::CMN_SPARE_LO] == '0)
		else $error("Spare common bits not low");

	idle_fill_a: assert property (@(posedge link_clk) disable iff (link_rst)
		link_load && !tx_rd_valid |=> lane_tx_bus[0][psb_pkg::IDLE_BIT] && !lane_tx_bus[0][psb_pkg::QUAL_BIT])
		else $error("Empty slot not sent as idle");

	symbol_map_a: assert property (@(posedge link_clk) disable iff (link_rst)
		link_load && tx_rd_valid |=> lane_tx_bus[0][psb_pkg::CHK_HI:psb_pkg::SYM_LO]
			== $past(tx_rd_word[0][psb_pkg::CHK_HI:psb_pkg::SYM_LO]))
		else $error("Transmit symbols misplaced");

	header_map_a: assert property (@(posedge link_clk) disable iff (link_rst)
		link_load && tx_rd_valid |=> lane_tx_bus[psb_pkg::LANES-1][psb_pkg::HDR_HI:psb_pkg::BLK_BIT]
			== $past(tx_rd_word[psb_pkg::LANES-1][psb_pkg::HDR_HI:psb_pkg::BLK_BIT]))
		else $error("Block start or header misplaced");

	power_map_a: assert property (@(posedge link_clk) disable iff (link_rst)
		lk_reg.state != psb_pkg::PSB_OFF |=> lane_tx_bus[0][psb_pkg::PWR_HI:psb_pkg::PWR_LO] == $past(lk_reg.ctl_s2.pwr[0])
			&& lane_tx_bus[0][psb_pkg::TX_W-1:psb_pkg::TX_SPARE_LO] == '0)
		else $error("Power field or spare transmit bits wrong");

	disabled_quiet_a: assert property (@(posedge link_clk) disable iff (link_rst)
		!lk_reg.en_s2 [*2] |=> common_cmd_out == '0)
		else $error("Common outputs active while disabled");

	rx_capture_a: assert property (@(posedge link_clk) disable iff (link_rst)
		lk_reg.state != psb_pkg::PSB_OFF && lane_rx_bus[0][psb_pkg::QUAL_BIT] |=> lk_reg.rx_push
			&& lk_reg.rx_word[0] == $past(lane_rx_bus[0][psb_pkg::LANE_W-1:0]))
		else $error("Qualified receive word not captured");

	overflow_hold_a: assert property (@(posedge clk) disable iff (reset)
		rx_overflow && !rx_overflow_clr |=> rx_overflow)
		else $error("Overflow flag lost without a clear");

endmodule

// ### psb_link_model.sv
// Far-end model that drives the receive vectors of every lane
`timescale 1ns/10ps
module psb_link_model (
	input  wire logic                                    link_clk,
	output logic [psb_pkg::LANES-1:0][psb_pkg::RX_W-1:0] lane_rx_bus
);
	localparam logic [83:0] NO_QUAL = ~(84'h8_0000_0000);

	initial lane_rx_bus = '0;

	// One word, then its inverse with qualifiers low, so a stale word never looks valid
	task automatic put_rx(input logic [psb_pkg::LANES*psb_pkg::LANE_W-1:0] w, input int gap);
		@(posedge link_clk);
		for (int l = 0; l < psb_pkg::LANES; l++)
			lane_rx_bus[l] <= {w[44:0], w[l*psb_pkg::LANE_W +: psb_pkg::LANE_W]};
		@(posedge link_clk);
		for (int l = 0; l < psb_pkg::LANES; l++)
			lane_rx_bus[l] <= ~lane_rx_bus[l] & NO_QUAL;
		repeat (gap) @(posedge link_clk);
	endtask
endmodule

// ### psb_top_tb_top.sv
// Self-checking bench for the PIPE simulation bus packer
`timescale 1ns/10ps
module psb_top_tb_top;
	localparam int L  = psb_pkg::LANES;
	localparam int LW = psb_pkg::LANE_W;
	localparam int WW = L * LW;
	logic                            clk = 1'h0;
	logic                            link_clk = 1'h0;
	logic                            reset = 1'h1;
	logic                            enable = 1'h0;
	logic [1:0]                      rate = 2'h0;
	logic [6:0]                      ctl = 7'h00;
	logic [L-1:0]                    inv = '0;
	logic [L-1:0][1:0]               pwr = '0;
	logic                            tx_valid = 1'h0;
	logic [WW-1:0]                   txw = '0;
	logic                            rx_ready = 1'h0;
	logic                            ovf_clr = 1'h0;
	logic [25:0]                     cmn_in = '0;
	logic                            tx_ready, rx_valid, rx_overflow, pclk_prev, rx_mode, chk_rx, saw_full;
	logic [16:0]                     cmn_out;
	logic [L-1:0][psb_pkg::TX_W-1:0] tx_bus;
	logic [L-1:0][psb_pkg::RX_W-1:0] rx_bus;
	logic [L-1:0][31:0]              sym_t, sym_r;
	logic [L-1:0][1:0]               flg_t, flg_r, hdr_t, hdr_r;
	logic [L-1:0]                    idl_t, idl_r, qul_t, qul_r, blk_t, blk_r;
	logic [WW-1:0]                   rxw, got_tx, w0;
	logic [WW-1:0]                   tx_q[$], rx_q[$];
	logic [31:0]                     rnd = 32'h0000_5f7d;
	logic [31:0]                     rdy_s = 32'h0000_5f7d;
	int                              errors = 0;
	int                              total_checks = 0;
	int                              n;

	always #4 clk = ~clk;
	// Offset so the two clocks never share an edge
	initial
	begin
		#13;
		forever #40 link_clk = ~link_clk;
	end

	for (genvar l = 0; l < L; l++)
	begin : g_map
		assign {hdr_t[l], blk_t[l], qul_t[l], idl_t[l], flg_t[l], sym_t[l]} = txw[l*LW +: LW];
		assign rxw[l*LW +: LW] = {hdr_r[l], blk_r[l], qul_r[l], idl_r[l], flg_r[l], sym_r[l]};
	end

	psb_top dut (.clk(clk), .reset(reset), .link_clk(link_clk), .ext_pipe_enable(enable),
		.line_rate_sel(rate), .receiver_detect_req(ctl[0]), .tx_voltage_margin(ctl[3:1]),
		.tx_swing_sel(ctl[4]), .tx_phy_reset(ctl[5]), .tx_deemphasis_sel(ctl[6]),
		.rx_invert_req(inv), .lane_power_state(pwr), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.lane_tx_symbols(sym_t), .tx_control_char_flag(flg_t), .tx_idle_state(idl_t),
		.tx_word_qualifier(qul_t), .tx_block_begin(blk_t), .tx_block_header(hdr_t),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .lane_rx_symbols(sym_r),
		.rx_control_char_flag(flg_r), .rx_idle_state(idl_r), .rx_word_qualifier(qul_r),
		.rx_block_begin(blk_r), .rx_block_header(hdr_r), .rx_overflow(rx_overflow),
		.rx_overflow_clr(ovf_clr), .common_cmd_in(cmn_in), .common_cmd_out(cmn_out),
		.lane_rx_bus(rx_bus), .lane_tx_bus(tx_bus));

	psb_link_model u_link (.link_clk(link_clk), .lane_rx_bus(rx_bus));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Lane 0 qualifier forced high so the word is carried, not skipped
	function automatic logic [WW-1:0] rand_word();
		logic [WW-1:0] w;
		for (int i = 0; i < 3; i++)
		begin
			repeat (32) rnd = lfsr(rnd);
			w = {w[WW-33:0], rnd};
		end
		w[psb_pkg::QUAL_BIT] = 1'h1;
		return w;
	endfunction

	task automatic cmp_word(input logic [WW-1:0] got, input logic [WW-1:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_field(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic fail_out();
		errors++;
		report_and_stop();
	endtask

	task automatic send_tx();
		logic [WW-1:0] w;
		logic          rdy;
		int            k;
		w = rand_word();
		tx_valid <= 1'h1;
		txw <= w;
		tx_q.push_back(w);
		for (k = 0; k < 400; k++)
		begin
			@(negedge clk);
			rdy = tx_ready;
			if (rdy !== 1'h1)
				saw_full = 1'h1;
			@(posedge clk);
			if (rdy === 1'h1)
				break;
		end
		if (k == 400)
			fail_out();
	endtask

	task automatic wait_drain();
		int k;
		for (k = 0; k < 8000 && tx_q.size() + rx_q.size() > 0; k++)
			@(posedge clk);
		if (k == 8000)
			fail_out();
	endtask

	// Link edges between two rises of the interface clock
	task automatic pclk_period(output int n);
		logic p;
		int   rises;
		p = 1'h1;
		n = 0;
		rises = 0;
		for (int k = 0; k < 40 && rises < 2; k++)
		begin
			@(negedge link_clk);
			if (p === 1'h0 && cmn_out[0] === 1'h1)
				rises++;
			if (rises == 1)
				n++;
			p = cmn_out[0];
		end
		if (rises < 2)
			fail_out();
	endtask

	always @(posedge clk)
	begin
		rdy_s <= lfsr(rdy_s);
		rx_ready <= rx_mode & rdy_s[0];
	end

	always @(negedge clk)
		if (chk_rx && rx_valid === 1'h1 && rx_ready === 1'h1)
			cmp_word(rxw, rx_q.size() > 0 ? rx_q.pop_front() : 'x);

	always @(negedge link_clk)
	begin
		pclk_prev <= cmn_out[0];
		if (cmn_out[0] === 1'h1 && pclk_prev === 1'h0 && tx_bus[0][psb_pkg::QUAL_BIT] === 1'h1)
		begin
			for (int l = 0; l < L; l++)
				got_tx[l*LW +: LW] = tx_bus[l][LW-1:0];
			cmp_word(got_tx, tx_q.size() > 0 ? tx_q.pop_front() : 'x);
		end
	end

	initial
	begin
		rx_mode = 1'h0;
		chk_rx = 1'h0;
		saw_full = 1'h0;
		repeat (16) @(posedge clk);
		reset <= 1'h0;
		repeat (10) @(negedge link_clk);
		cmp_field(cmn_out, 0);
		for (int l = 0; l < L; l++)
			cmp_field(tx_bus[l][LW-1:0], 39'h04_0000_0000);
		@(posedge clk);
		enable <= 1'h1;
		for (int r = 0; r < 4; r++)
		begin
			@(posedge clk);
			w0 = rand_word();
			rate <= 2'(r);
			ctl <= w0[6:0];
			inv <= w0[8:7];
			pwr <= w0[12:9];
			cmn_in <= w0[38:13];
			repeat (12) @(negedge link_clk);
			cmp_field(cmn_out[16:1], {7'h00, ctl, (r == 3) ? 2'h0 : 2'(r)});
			for (int l = 0; l < L; l++)
				cmp_field(tx_bus[l][69:39], {28'h000_0000, pwr[l], inv[l]});
			pclk_period(n);
			cmp_field(n, (r == 0 || r == 3) ? 4 : 2);
			@(posedge clk);
			for (int i = 0; i < ((r == 0) ? 40 : 6); i++)
				send_tx();
			tx_valid <= 1'h0;
			wait_drain();
		end
		cmp_field(saw_full, 1'h1);
		rx_mode <= 1'h1;
		chk_rx = 1'h1;
		for (int i = 0; i < 24; i++)
		begin
			w0 = rand_word();
			rx_q.push_back(w0);
			u_link.put_rx(w0, i % 3);
		end
		wait_drain();
		rx_mode <= 1'h0;
		chk_rx = 1'h0;
		repeat (4) @(posedge clk);
		w0 = rand_word();
		u_link.put_rx(w0, 0);
		for (int i = 0; i < 40; i++)
			u_link.put_rx(rand_word(), 0);
		for (int k = 0; k < 40 && rx_overflow !== 1'h1; k++)
			@(negedge clk);
		cmp_field(rx_overflow, 1'h1);
		cmp_word(rxw, w0);
		@(posedge clk);
		ovf_clr <= 1'h1;
		@(posedge clk);
		ovf_clr <= 1'h0;
		repeat (3) @(negedge clk);
		cmp_field(rx_overflow, 1'h0);
		report_and_stop();
	end
endmodule
